// >>> hw/emtp_core.sv
// external memory trigger pipeline: apb registers, trigger arbitration, access and refresh
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
module emtp_core
  import emtp_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // debug halt level
  input wire logic DEBUG_MODE,
  // memory pins
  output logic [15:0] MEM_ADDR,
  output logic [31:0] MEM_DATA_O,
  output logic MEM_DATA_OE,
  input wire logic [31:0] MEM_DATA_I,
  output logic MEM_CHIP_SELECT_N,
  output logic MEM_READ_STROBE_N,
  output logic MEM_WRITE_STROBE_N,
  output logic MEM_REFRESH_N
);
  emtp_state_e st_q;
  logic ph_q, icyc_end;
  logic [7:0] ctrl_q;
  logic [7:0] refresh_divider_q;
  logic [1:0] refresh_prescale_sel_q;
  logic refresh_enable_q, debug_refresh_enable_q, one_shot_refresh_q;
  logic [15:0] base_address_reg_q;
  logic pend_v_q, pend_wr_q, calc_v_q, calc_wr_q, acc_wr_q;
  logic [15:0] pend_off_q, calc_addr_q;
  logic [31:0] pend_dat_q, calc_dat_q;
  logic inc_q;
  logic [3:0] cnt_q;
  logic [31:0] read_data_reg_q, read_data_buffer_q;
  logic rdr_full_q, read_buffer_full_flag_q, slow_cap_q;
  logic refresh_req_q, tick;
  logic [31:0] din_m_q, din_s_q;
  logic dbg_m_q, dbg_s_q;
  logic apb_acc, wr_hit, rd_trig, wr_trig, rdata_rd, mapped;
  logic iface_busy_flag, acc_last, op_free, calc_move, cap, start_acc, start_ref;
  logic [31:0] rd_mux;
  emtp_mode_e mode;

  function automatic logic [15:0] word_addr(input logic [15:0] base, input logic [15:0] off);
    word_addr = base - off;
  endfunction : word_addr

  // pin synchronisers
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      din_m_q <= 32'h0000_0000;
      din_s_q <= 32'h0000_0000;
      dbg_m_q <= 1'b0;
      dbg_s_q <= 1'b0;
    end else begin
      din_m_q <= MEM_DATA_I;
      din_s_q <= din_m_q;
      dbg_m_q <= DEBUG_MODE;
      dbg_s_q <= dbg_m_q;
    end
  end

  // apb decode
  assign apb_acc = PSEL && PENABLE && PREADY;
  assign wr_hit = apb_acc && PWRITE;
  assign rd_trig = wr_hit && (PADDR == OFS_RD_TRIG);
  assign wr_trig = wr_hit && (PADDR == OFS_WR_TRIG);
  assign rdata_rd = apb_acc && !PWRITE && (PADDR == OFS_RDATA);
  assign mode = emtp_mode_e'(ctrl_q[CTRL_MODE_LSB +: 2]);
  assign iface_busy_flag = pend_v_q || calc_v_q || (st_q == ST_ACCESS);

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (PADDR)
      OFS_CTRL: rd_mux = {24'h000000, ctrl_q};
      OFS_REFRESH: rd_mux = {19'h00000, debug_refresh_enable_q, one_shot_refresh_q,
                             refresh_enable_q, refresh_prescale_sel_q, refresh_divider_q};
      OFS_STATUS: rd_mux = {28'h0000000, refresh_req_q, rdr_full_q,
                            read_buffer_full_flag_q, iface_busy_flag};
      OFS_BASE: rd_mux = {16'h0000, base_address_reg_q};
      OFS_RDATA: rd_mux = read_data_reg_q;
      OFS_RD_TRIG, OFS_WR_TRIG: rd_mux = 32'h0000_0000;
      default: mapped = 1'b0;
    endcase
  end

  // one wait state, then answer
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && PENABLE && !PREADY;
      PSLVERR <= PSEL && PENABLE && !PREADY && !mapped;
      if (PSEL && PENABLE && !PREADY && !PWRITE) begin
        PRDATA <= rd_mux;
      end
    end
  end

  // software control registers
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= CTRL_RST;
      refresh_divider_q <= REF_DIV_RST;
      refresh_prescale_sel_q <= REF_SEL_RST;
      refresh_enable_q <= 1'b0;
      debug_refresh_enable_q <= 1'b0;
    end else if (wr_hit && PADDR == OFS_CTRL) begin
      ctrl_q <= PWDATA[7:0];
    end else if (wr_hit && PADDR == OFS_REFRESH) begin
      refresh_divider_q <= PWDATA[REF_DIV_LSB +: 8];
      refresh_prescale_sel_q <= PWDATA[REF_SEL_LSB +: 2];
      refresh_enable_q <= PWDATA[REF_EN_BIT];
      debug_refresh_enable_q <= PWDATA[REF_DBG_BIT];
    end
  end

  emtp_refresh_timer u_timer (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .divider(refresh_divider_q),
    .prescale_sel(refresh_prescale_sel_q),
    .run(refresh_enable_q || (debug_refresh_enable_q && dbg_s_q)),
    .tick_q(tick)
  );

  // instruction cycle phase
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ph_q <= 1'b0;
    end else begin
      ph_q <= !ph_q;
    end
  end
  assign icyc_end = ph_q;

  assign acc_last = (st_q != ST_IDLE) && (cnt_q == 4'h1);
  assign op_free = icyc_end && ((st_q == ST_IDLE) || acc_last);
  assign calc_move = icyc_end && pend_v_q && !calc_v_q
                     && ((st_q == ST_IDLE) || (st_q == ST_ACCESS && cnt_q == 4'h1));
  assign start_ref = op_free && refresh_req_q && (st_q != ST_REFRESH);
  assign start_acc = op_free && !start_ref && calc_v_q
                     && !read_buffer_full_flag_q && !(cap && rdr_full_q);

  // refresh request: set wins over clear
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      refresh_req_q <= 1'b0;
      one_shot_refresh_q <= 1'b0;
    end else begin
      one_shot_refresh_q <= wr_hit && PADDR == OFS_REFRESH && PWDATA[REF_ONESHOT_BIT];
      if (tick || one_shot_refresh_q) begin
        refresh_req_q <= 1'b1;
      end else if (icyc_end && st_q == ST_REFRESH && acc_last) begin
        refresh_req_q <= 1'b0;
      end
    end
  end

  // pending trigger slot
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pend_v_q <= 1'b0;
      pend_wr_q <= 1'b0;
      pend_off_q <= 16'h0000;
      pend_dat_q <= 32'h0000_0000;
    end else if (rd_trig || wr_trig) begin
      pend_v_q <= 1'b1;
      pend_wr_q <= wr_trig;
      pend_off_q <= rd_trig ? PWDATA[15:0] : 16'h0000;
      pend_dat_q <= PWDATA;
    end else if (calc_move) begin
      pend_v_q <= 1'b0;
    end
  end

  // address calculation stage, held until the access slot frees
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      calc_v_q <= 1'b0;
      calc_wr_q <= 1'b0;
      calc_addr_q <= 16'h0000;
      calc_dat_q <= 32'h0000_0000;
    end else if (calc_move) begin
      calc_v_q <= 1'b1;
      calc_wr_q <= pend_wr_q;
      calc_addr_q <= word_addr(base_address_reg_q, pend_off_q);
      calc_dat_q <= pend_dat_q;
    end else if (start_acc) begin
      calc_v_q <= 1'b0;
    end
  end

  // base post-increment one instruction cycle after calculation
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      inc_q <= 1'b0;
      base_address_reg_q <= BASE_RST;
    end else begin
      if (calc_move) begin
        inc_q <= pend_wr_q ? ctrl_q[CTRL_WINC_BIT] : ctrl_q[CTRL_RINC_BIT];
      end else if (icyc_end) begin
        inc_q <= 1'b0;
      end
      if (wr_hit && PADDR == OFS_BASE) begin
        base_address_reg_q <= PWDATA[15:0];
      end else if (icyc_end && inc_q) begin
        base_address_reg_q <= base_address_reg_q + 16'h0001;
      end
    end
  end

  // access and refresh sequencer
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      acc_wr_q <= 1'b0;
    end else if (start_ref) begin
      st_q <= ST_REFRESH;
      cnt_q <= REFRESH_ICYC;
    end else if (start_acc) begin
      st_q <= ST_ACCESS;
      cnt_q <= (ctrl_q[CTRL_LEN_LSB +: 4] == 4'h0) ? 4'h1 : ctrl_q[CTRL_LEN_LSB +: 4];
      acc_wr_q <= calc_wr_q;
    end else if (op_free) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
    end else if (icyc_end && st_q != ST_IDLE) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  // memory pins
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      MEM_ADDR <= 16'h0000;
      MEM_DATA_O <= 32'h0000_0000;
      MEM_DATA_OE <= 1'b0;
      MEM_CHIP_SELECT_N <= 1'b1;
      MEM_READ_STROBE_N <= 1'b1;
      MEM_WRITE_STROBE_N <= 1'b1;
      MEM_REFRESH_N <= 1'b1;
    end else if (start_acc) begin
      MEM_ADDR <= calc_addr_q;
      MEM_DATA_O <= calc_dat_q;
      MEM_DATA_OE <= calc_wr_q;
      MEM_CHIP_SELECT_N <= 1'b0;
      MEM_READ_STROBE_N <= calc_wr_q;
      MEM_WRITE_STROBE_N <= !calc_wr_q;
      MEM_REFRESH_N <= 1'b1;
    end else if (start_ref || op_free) begin
      MEM_DATA_OE <= 1'b0;
      MEM_CHIP_SELECT_N <= 1'b1;
      MEM_READ_STROBE_N <= 1'b1;
      MEM_WRITE_STROBE_N <= 1'b1;
      MEM_REFRESH_N <= !start_ref;
    end
  end

  // read capture moment by mode
  always_comb begin
    case (mode)
      MODE_FAST_DRAM: cap = !ph_q && st_q == ST_ACCESS && !acc_wr_q && cnt_q == 4'h1;
      MODE_SLOW_DRAM: cap = icyc_end && slow_cap_q;
      default: cap = icyc_end && st_q == ST_ACCESS && !acc_wr_q && acc_last;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      slow_cap_q <= 1'b0;
    end else if (icyc_end) begin
      slow_cap_q <= st_q == ST_ACCESS && !acc_wr_q && acc_last;
    end
  end

  // read data register and intermediate buffer
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      read_data_reg_q <= 32'h0000_0000;
      read_data_buffer_q <= 32'h0000_0000;
      rdr_full_q <= 1'b0;
      read_buffer_full_flag_q <= 1'b0;
    end else if (rdata_rd) begin
      if (read_buffer_full_flag_q) begin
        read_data_reg_q <= read_data_buffer_q;
        read_buffer_full_flag_q <= cap;
        read_data_buffer_q <= din_s_q;
      end else begin
        rdr_full_q <= cap;
        read_data_reg_q <= din_s_q;
      end
    end else if (cap) begin
      if (!rdr_full_q) begin
        rdr_full_q <= 1'b1;
        read_data_reg_q <= din_s_q;
      end else begin
        read_buffer_full_flag_q <= 1'b1;
        read_data_buffer_q <= din_s_q;
      end
    end
  end

  // checks
  sequence s_refresh_run;
    !MEM_REFRESH_N ##1 !MEM_REFRESH_N;
  endsequence

  property p_refresh_pins;
    @(posedge REF_CLK) disable iff (!RST_N)
      !MEM_REFRESH_N |-> MEM_CHIP_SELECT_N && MEM_READ_STROBE_N && MEM_WRITE_STROBE_N
        && !MEM_DATA_OE && $stable(MEM_ADDR);
  endproperty
  a_refresh_pins: assert property (p_refresh_pins) else $error("pins active in refresh");

  property p_refresh_len;
    @(posedge REF_CLK) disable iff (!RST_N)
      $fell(MEM_REFRESH_N) |-> s_refresh_run ##1 !MEM_REFRESH_N [*2] ##1 MEM_REFRESH_N;
  endproperty
  a_refresh_len: assert property (p_refresh_len) else $error("refresh length wrong");

  property p_refresh_clear;
    @(posedge REF_CLK) disable iff (!RST_N)
      $rose(MEM_REFRESH_N) && !$past(tick) && !$past(one_shot_refresh_q) |-> !refresh_req_q;
  endproperty
  a_refresh_clear: assert property (p_refresh_clear) else $error("request kept");

  property p_oneshot;
    @(posedge REF_CLK) disable iff (!RST_N)
      one_shot_refresh_q |=> refresh_req_q;
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot lost");

  property p_ref_first;
    @(posedge REF_CLK) disable iff (!RST_N)
      op_free && refresh_req_q && st_q != ST_REFRESH |=> st_q == ST_REFRESH;
  endproperty
  a_ref_first: assert property (p_ref_first) else $error("refresh lost arbitration");

  property p_busy_now;
    @(posedge REF_CLK) disable iff (!RST_N)
      rd_trig || wr_trig |=> iface_busy_flag;
  endproperty
  a_busy_now: assert property (p_busy_now) else $error("busy late");

  property p_idle_start;
    @(posedge REF_CLK) disable iff (!RST_N)
      (rd_trig || wr_trig) && st_q == ST_IDLE && !pend_v_q && !calc_v_q && !refresh_req_q
        && !read_buffer_full_flag_q && !tick && !ph_q |-> ##[1:4] st_q == ST_ACCESS;
  endproperty
  a_idle_start: assert property (p_idle_start) else $error("access late from idle");

  property p_no_gap;
    @(posedge REF_CLK) disable iff (!RST_N)
      acc_last && icyc_end && st_q == ST_ACCESS && calc_v_q && !refresh_req_q
        && !read_buffer_full_flag_q && !(cap && rdr_full_q) |=> st_q == ST_ACCESS;
  endproperty
  a_no_gap: assert property (p_no_gap) else $error("gap between accesses");

  property p_buf_hold;
    @(posedge REF_CLK) disable iff (!RST_N)
      read_buffer_full_flag_q |-> !start_acc;
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("access with buffer full");

  property p_inc;
    @(posedge REF_CLK) disable iff (!RST_N)
      calc_move && (pend_wr_q ? ctrl_q[CTRL_WINC_BIT] : ctrl_q[CTRL_RINC_BIT])
        && !(wr_hit && PADDR == OFS_BASE) ##1 !(wr_hit && PADDR == OFS_BASE) [*2]
        |=> base_address_reg_q == $past(base_address_reg_q, 3) + 16'h0001;
  endproperty
  a_inc: assert property (p_inc) else $error("base not incremented");
endmodule : emtp_core

// >>> hw/emtp_refresh_timer.sv
// refresh timer: programmable divider followed by a 1/8/64 prescaler
`timescale 1ns/100ps
module emtp_refresh_timer
  import emtp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // settings
  input wire logic [7:0] divider,
  input wire logic [1:0] prescale_sel,
  input wire logic run,
  // request pulse
  output logic tick_q
);
  logic [7:0] div_cnt_q;
  logic [6:0] pre_cnt_q;
  logic div_wrap;
  logic [6:0] factor;

  function automatic logic [6:0] pre_factor(input logic [1:0] sel);
    case (sel)
      PRE_64: pre_factor = PRE_F64;
      PRE_8: pre_factor = PRE_F8;
      default: pre_factor = PRE_F1;
    endcase
  endfunction : pre_factor

  assign factor = pre_factor(prescale_sel);
  assign div_wrap = run && (div_cnt_q >= divider);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q <= 8'h00;
    end else if (!run || div_wrap) begin
      div_cnt_q <= 8'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_q <= 7'h00;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (!run) begin
        pre_cnt_q <= 7'h00;
      end else if (div_wrap) begin
        if (pre_cnt_q + 7'h01 >= factor) begin
          pre_cnt_q <= 7'h00;
          tick_q <= 1'b1;
        end else begin
          pre_cnt_q <= pre_cnt_q + 7'h01;
        end
      end
    end
  end
endmodule : emtp_refresh_timer

// >>> shared/emtp_pkg.sv
// package: register map, field layout, reset values and timing of the trigger pipeline
package emtp_pkg;
  // apb byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_REFRESH = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_BASE = 8'h0C;
  localparam logic [7:0] OFS_RD_TRIG = 8'h10;
  localparam logic [7:0] OFS_WR_TRIG = 8'h14;
  localparam logic [7:0] OFS_RDATA = 8'h18;
  // control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RINC_BIT = 2;
  localparam int CTRL_WINC_BIT = 3;
  localparam int CTRL_LEN_LSB = 4;
  localparam logic [7:0] CTRL_RST = 8'h10;
  // refresh control fields
  localparam int REF_DIV_LSB = 0;
  localparam int REF_SEL_LSB = 8;
  localparam int REF_EN_BIT = 10;
  localparam int REF_ONESHOT_BIT = 11;
  localparam int REF_DBG_BIT = 12;
  localparam logic [7:0] REF_DIV_RST = 8'h00;
  localparam logic [1:0] REF_SEL_RST = 2'h0;
  // status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_BUF_BIT = 1;
  localparam int STAT_RDR_BIT = 2;
  localparam int STAT_REFREQ_BIT = 3;
  localparam logic [15:0] BASE_RST = 16'h0000;
  // prescaler codes and factors
  localparam logic [1:0] PRE_64 = 2'h0;
  localparam logic [1:0] PRE_8 = 2'h1;
  localparam logic [1:0] PRE_1 = 2'h2;
  localparam logic [6:0] PRE_F64 = 7'h40;
  localparam logic [6:0] PRE_F8 = 7'h08;
  localparam logic [6:0] PRE_F1 = 7'h01;
  // timing: clocks per instruction cycle, refresh length in instruction cycles
  localparam int CLK_PER_ICYC = 2;
  localparam logic [3:0] REFRESH_ICYC = 4'h2;
  // access modes
  typedef enum logic [1:0] {MODE_SRAM, MODE_FAST_DRAM, MODE_SLOW_DRAM, MODE_SRAM_ALT} emtp_mode_e;
  typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_REFRESH} emtp_state_e;
endpackage : emtp_pkg

// >>> verification/emtp_mem_model.sv
// memory device model on the far side of the external memory pins
`timescale 1ns/100ps
module emtp_mem_model (
  // clock
  input wire logic clk,
  // memory pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic oe,
  input wire logic [15:0] addr,
  input wire logic [31:0] data_o,
  output logic [31:0] data_i
);
  logic [31:0] mem [0:65535];
  logic [31:0] last_q = 32'h0;
  // store while selected with the write strobe low
  always @(posedge clk) begin
    if (!cs_n && !wr_n && oe) begin
      mem[addr] <= data_o;
    end
  end
  // remember the last word read
  always @(posedge clk) begin
    if (!cs_n && !rd_n) begin
      last_q <= mem[addr];
    end
  end
  // asynchronous read while selected; a released bus shows the inverse of the last word
  assign data_i = (!cs_n && !rd_n) ? mem[addr] : ~last_q;
endmodule : emtp_mem_model

// >>> verification/tb_top.sv
// self-checking bench for the trigger pipeline with a queue-based model
`timescale 1ns/100ps
module tb_top
  import emtp_pkg::*;
();
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, dbg, pready, pslverr, oe, cs_n, rd_n, wr_n, ref_n;
  logic prev_ref = 1'b1;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, mdo, mdi, rv, d0;
  logic [15:0] maddr, ref_addr;
  logic er;
  int fail_count = 0, checks = 0, cyc = 0, falls = 0, last_fall = 0, gap = 0;
  int base, winc, n;
  int exp_mem [int];
  int rq [$];
  int pre_f [3] = '{64, 8, 1};
  int divs [3] = '{0, 2, 255};
  always #2.5 clk = ~clk;
  emtp_core u_emtp_core (.REF_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .DEBUG_MODE(dbg), .MEM_ADDR(maddr), .MEM_DATA_O(mdo),
    .MEM_DATA_OE(oe), .MEM_DATA_I(mdi), .MEM_CHIP_SELECT_N(cs_n),
    .MEM_READ_STROBE_N(rd_n), .MEM_WRITE_STROBE_N(wr_n), .MEM_REFRESH_N(ref_n));
  emtp_mem_model u_emtp_mem_model (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .oe(oe), .addr(maddr), .data_o(mdo), .data_i(mdi));
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_reg
  task automatic cmp_pin(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_pin
  task automatic finish_test();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  // one apb transfer, request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      fail_count++;
    end
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp_reg(rv, exp);
  endtask : rd_chk
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      k++;
    end while (rv[STAT_BUSY_BIT] !== 1'b0 && k < 100);
    if (rv[STAT_BUSY_BIT] !== 1'b0) begin
      fail_count++;
    end
    repeat (4) @(posedge clk);
  endtask : wait_idle
  // model: write trigger stores at base, read trigger queues base minus offset
  task automatic wtrig(input logic [31:0] d);
    apb(1'b1, OFS_WR_TRIG, d);
    exp_mem[base] = d;
    base = (base + winc) & 16'hFFFF;
  endtask : wtrig
  task automatic rtrig(input int off, input int repl);
    apb(1'b1, OFS_RD_TRIG, off);
    if (repl != 0) begin
      rq[rq.size() - 1] = exp_mem[base - off];
    end else begin
      rq.push_back(exp_mem[base - off]);
    end
  endtask : rtrig
  task automatic pop();
    rd_chk(OFS_RDATA, rq.pop_front());
  endtask : pop
  // refresh pin monitor: selects, strobes, data enable and address during refresh
  always @(negedge clk) begin
    cyc++;
    if (ref_n === 1'b0) begin
      cmp_pin({cs_n, rd_n, wr_n, oe}, 4'hE);
      cmp_reg({16'h0, maddr}, {16'h0, ref_addr});
      if (prev_ref === 1'b1) begin
        falls++;
        gap = cyc - last_fall;
        last_fall = cyc;
      end
    end else begin
      ref_addr = maddr;
    end
    prev_ref = ref_n;
  end
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    finish_test();
  end
  initial begin
    {psel, penable, pwrite, dbg} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rv = $urandom(32'hc71d);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(OFS_CTRL, {24'h0, CTRL_RST});
    rd_chk(OFS_REFRESH, 32'h0);
    rd_chk(OFS_STATUS, 32'h0);
    rd_chk(OFS_BASE, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    cmp_pin({3'h0, er}, 4'h1);
    // access length m + 2: the two-flop data sync needs more than one icyc per read
    for (int m = 0; m < 4; m++) begin
      base = $urandom_range(16'hFF00, 16'h0010);
      winc = 1;
      apb(1'b1, OFS_CTRL, m | 8 | ((m + 2) << CTRL_LEN_LSB));
      apb(1'b1, OFS_BASE, base);
      wtrig($urandom);
      wtrig($urandom);
      wait_idle();
      rd_chk(OFS_BASE, base);
      winc = 0;
      apb(1'b1, OFS_CTRL, m | ((m + 2) << CTRL_LEN_LSB));
      rtrig(2, 0);
      rtrig(1, 0);
      wait_idle();
      rd_chk(OFS_STATUS, 32'h6);
      rtrig(2, 0);
      repeat (20) @(posedge clk);
      rd_chk(OFS_STATUS, 32'h7);
      pop();
      pop();
      wait_idle();
      pop();
      rd_chk(OFS_STATUS, 32'h0);
    end
    // newer trigger replaces the pending one; write then read in arrival order
    apb(1'b1, OFS_CTRL, 8 << CTRL_LEN_LSB);
    base = $urandom_range(16'hFF00, 16'h0010);
    apb(1'b1, OFS_BASE, base);
    d0 = $urandom;
    wtrig(d0);
    rtrig(1, 0);
    rtrig(0, 1);
    wait_idle();
    pop();
    rd_chk(OFS_STATUS, 32'h0);
    // periodic refresh at each prescale code
    apb(1'b1, OFS_CTRL, 32'h11);
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, OFS_REFRESH, divs[s] | (s << REF_SEL_LSB) | (1 << REF_EN_BIT));
      n = falls;
      for (int t = 0; t < 2000 && falls < n + 3; t++) begin
        @(posedge clk);
      end
      cmp_reg(gap, (divs[s] + 1) * pre_f[s]);
    end
    apb(1'b1, OFS_REFRESH, 32'h0);
    repeat (20) @(posedge clk);
    n = falls;
    apb(1'b1, OFS_REFRESH, 1 << REF_ONESHOT_BIT);
    repeat (100) @(posedge clk);
    cmp_reg(falls - n, 1);
    rd_chk(OFS_STATUS, 32'h0);
    // debug-only refresh runs while the halt level is high
    dbg <= 1'b1;
    apb(1'b1, OFS_REFRESH, 32'h9 | (2 << REF_SEL_LSB) | (1 << REF_DBG_BIT));
    n = falls;
    for (int t = 0; t < 500 && falls < n + 3; t++) begin
      @(posedge clk);
    end
    cmp_reg(gap, (9 + 1) * pre_f[2]);
    dbg <= 1'b0;
    finish_test();
  end
endmodule : tb_top
